// >>> hw/ifpd_defs.svh
// Offsets, field positions, address codes and reset values for the IF divider register bank.
`ifndef IFPD_DEFS_SVH
`define IFPD_DEFS_SVH

// APB byte offsets.
`define IFPD_OFS_WORD 12'h000
`define IFPD_OFS_CTRL 12'h004
`define IFPD_OFS_COUNT 12'h008
`define IFPD_OFS_REF 12'h00C
`define IFPD_OFS_TEST 12'h010
`define IFPD_OFS_STAT 12'h014

// Serial word address codes, matched on the low bits.
`define IFPD_CNT_CODE 4'h7
`define IFPD_REF_CODE 5'h0F
`define IFPD_TST_CODE 6'h1F

// Counter and reference word fields.
`define IFPD_MAIN_LSB 4
`define IFPD_SWAL_LSB 13
`define IFPD_REFD_LSB 5

// Control and status bits.
`define IFPD_CTRL_DEF_BIT 0
`define IFPD_STAT_CNT_BIT 0
`define IFPD_STAT_REF_BIT 1
`define IFPD_STAT_TST_BIT 2
`define IFPD_STAT_BAD_BIT 3

// Reset values and built-in defaults.
`define IFPD_WORD_RST 24'h00_0000
`define IFPD_DEF_SWAL 4'h0
`define IFPD_DEF_MAIN 9'h0_40
`define IFPD_DEF_REFD 9'h0_10

`endif

// >>> hw/ifpd_pkg.sv
// Types shared by the IF divider register bank.
package ifpd_pkg;

  typedef enum logic [3:0] {
    WD_NONE = 4'b0001,
    WD_CNT = 4'b0010,
    WD_REF = 4'b0100,
    WD_TST = 4'b1000
  } ifpd_word_e;

  typedef logic [23:0] ifpd_word_t;

endpackage : ifpd_pkg

// >>> hw/ifpd_decode.sv
// Address decoder for a 24-bit serial control word.
`include "ifpd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ifpd_decode (
  input wire logic [23:0] word, // Control word
  output ifpd_pkg::ifpd_word_e kind // Target register
);

  // Longest pattern of trailing ones is checked first so codes cannot alias.
  always_comb
  begin
    if (word[5:0] == `IFPD_TST_CODE)
    begin
      kind = ifpd_pkg::WD_TST;
    end
    else if (word[4:0] == `IFPD_REF_CODE)
    begin
      kind = ifpd_pkg::WD_REF;
    end
    else if (word[3:0] == `IFPD_CNT_CODE)
    begin
      kind = ifpd_pkg::WD_CNT;
    end
    else
    begin
      kind = ifpd_pkg::WD_NONE;
    end
  end

endmodule : ifpd_decode

`default_nettype wire

// >>> hw/ifpd_regs.sv
// IF divider register bank with APB access and divider outputs.
`include "ifpd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Low bits 0111 select counter word.
// - Counter values used only when default_select clear.
// - Swallow count is four bits, 0 to 15.
// - Main count nine bits, never zero; zero is still loaded and sets bad_value.
// - Ratio is sixteen main plus swallow.
// - Low bits 01111 select reference word.
// - Reference value used only when default_select clear.
// - Reference divide nine bits, 2 to 511; 0 and 1 are still loaded and set bad_value.
// - Low bits 011111 select test word.
module ifpd_regs (
  input wire logic CLK, // 10 MHz clock
  input wire logic SRST, // Synchronous reset, high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  output logic [3:0] IF_SWALLOW, // Swallow count in use
  output logic [8:0] IF_MAIN, // Main count in use
  output logic [8:0] IF_REF_DIV, // Reference divide in use
  output logic [13:0] IF_RATIO, // Feedback ratio in use
  output logic TEST_ACTIVE, // Test word honoured
  output logic [23:0] TEST_WORD // Stored test word
);

  typedef struct packed {
    logic default_select;
    logic [3:0] swallow;
    logic [8:0] main_cnt;
    logic [8:0] ref_div;
    logic [23:0] test_word;
    logic test_seen;
    logic cnt_seen;
    logic ref_seen;
    logic bad_value;
    logic [31:0] rdata;
    logic err;
    logic [3:0] out_swallow;
    logic [8:0] out_main;
    logic [8:0] out_ref;
    logic [13:0] out_ratio;
    logic out_test;
  } ifpd_state_s;

  ifpd_state_s st;
  ifpd_state_s next_st;
  ifpd_pkg::ifpd_word_e kind;
  logic [23:0] wr_word;
  logic access;
  logic [3:0] eff_swallow;
  logic [8:0] eff_main;
  logic [8:0] eff_ref;

  // ---------------------------------------------------------------
  // Word decode
  // ---------------------------------------------------------------
  assign wr_word = PWDATA[23:0];
  assign access = PSEL & PENABLE;

  ifpd_decode u_decode (
    .word(wr_word),
    .kind(kind)
  );

  // Checks whether a counter word holds a legal pair of counts.
  function automatic logic cnt_ok(input logic [23:0] w);
    logic [3:0] a;
    logic [8:0] b;
    a = w[`IFPD_SWAL_LSB +: 4];
    b = w[`IFPD_MAIN_LSB +: 9];
    cnt_ok = (b != 9'h000) && ({5'h00, a} < b);
  endfunction : cnt_ok

  // ---------------------------------------------------------------
  // Effective divider values
  // ---------------------------------------------------------------
  always_comb
  begin
    if (!st.default_select)
    begin
      eff_swallow = st.swallow;
      eff_main = st.main_cnt;
      eff_ref = st.ref_div;
    end
    else
    begin
      eff_swallow = `IFPD_DEF_SWAL;
      eff_main = `IFPD_DEF_MAIN;
      eff_ref = `IFPD_DEF_REFD;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.err = 1'b0;
    if (PSEL && !PENABLE)
    begin
      next_st.rdata = 32'h0000_0000;
      unique case (PADDR)
        `IFPD_OFS_WORD:
        begin
          next_st.err = !PWRITE;
        end
        `IFPD_OFS_CTRL:
        begin
          next_st.rdata[`IFPD_CTRL_DEF_BIT] = st.default_select;
        end
        `IFPD_OFS_COUNT:
        begin
          next_st.rdata[23:0] = {7'h08, st.swallow, st.main_cnt, `IFPD_CNT_CODE};
          next_st.err = PWRITE;
        end
        `IFPD_OFS_REF:
        begin
          next_st.rdata[23:0] = {10'h0C2, st.ref_div, `IFPD_REF_CODE};
          next_st.err = PWRITE;
        end
        `IFPD_OFS_TEST:
        begin
          next_st.rdata[23:0] = st.test_word;
          next_st.err = PWRITE;
        end
        `IFPD_OFS_STAT:
        begin
          next_st.rdata[`IFPD_STAT_CNT_BIT] = st.cnt_seen;
          next_st.rdata[`IFPD_STAT_REF_BIT] = st.ref_seen;
          next_st.rdata[`IFPD_STAT_TST_BIT] = st.test_seen;
          next_st.rdata[`IFPD_STAT_BAD_BIT] = st.bad_value;
          next_st.err = PWRITE;
        end
        default:
        begin
          next_st.err = 1'b1;
        end
      endcase
    end
    if (access && PWRITE && !st.err)
    begin
      if (PADDR == `IFPD_OFS_CTRL)
      begin
        next_st.default_select = PWDATA[`IFPD_CTRL_DEF_BIT];
      end
      else if (PADDR == `IFPD_OFS_WORD)
      begin
        unique case (kind)
          ifpd_pkg::WD_CNT:
          begin
            next_st.swallow = wr_word[`IFPD_SWAL_LSB +: 4];
            next_st.main_cnt = wr_word[`IFPD_MAIN_LSB +: 9];
            next_st.cnt_seen = 1'b1;
            next_st.bad_value = st.bad_value | !cnt_ok(wr_word);
          end
          ifpd_pkg::WD_REF:
          begin
            next_st.ref_div = wr_word[`IFPD_REFD_LSB +: 9];
            next_st.ref_seen = 1'b1;
            next_st.bad_value = st.bad_value | (wr_word[`IFPD_REFD_LSB +: 9] < 9'h002);
          end
          ifpd_pkg::WD_TST:
          begin
            next_st.test_word = wr_word;
            next_st.test_seen = 1'b1;
          end
          ifpd_pkg::WD_NONE:
          begin
            next_st.err = 1'b0;
          end
        endcase
      end
      else if (PADDR == `IFPD_OFS_STAT)
      begin
        next_st.bad_value = 1'b0;
      end
    end
    next_st.out_swallow = eff_swallow;
    next_st.out_main = eff_main;
    next_st.out_ref = eff_ref;
    next_st.out_ratio = {1'b0, eff_main, 4'h0} + {10'h000, eff_swallow};
    next_st.out_test = !st.default_select && st.test_seen;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st <= '0;
      st.default_select <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = access & st.err;
  assign PRDATA = st.rdata;
  assign IF_SWALLOW = st.out_swallow;
  assign IF_MAIN = st.out_main;
  assign IF_REF_DIV = st.out_ref;
  assign IF_RATIO = st.out_ratio;
  assign TEST_ACTIVE = st.out_test;
  assign TEST_WORD = st.test_word;

endmodule : ifpd_regs

`default_nettype wire

// >>> test/ifpd_regs_chk.sv
// Port assertions for the IF divider register bank.
`include "ifpd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifpd_regs_chk (
  input wire logic CLK, // Clock
  input wire logic SRST, // Reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Enable
  input wire logic PWRITE, // Write
  input wire logic [11:0] PADDR, // Address
  input wire logic [31:0] PWDATA, // Data
  input wire logic PREADY, // Ready
  input wire logic PSLVERR, // Error
  input wire logic [3:0] IF_SWALLOW, // Swallow
  input wire logic [8:0] IF_MAIN, // Main
  input wire logic [8:0] IF_REF_DIV, // Reference
  input wire logic [13:0] IF_RATIO, // Ratio
  input wire logic TEST_ACTIVE // Test
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic acc;
  logic dflt;
  logic wr0;
  assign acc = PSEL && PENABLE;
  assign wr0 = acc && PWRITE && PADDR == `IFPD_OFS_WORD && !dflt;
  // Shadow of the default-select bit.
  always_ff @(posedge CLK)
  begin
    if (SRST || (acc && PWRITE && PADDR == `IFPD_OFS_CTRL))
      dflt <= SRST || PWDATA[0];
  end
  bus_rdy_a: assert property (PREADY == acc)
    else $error("ready");
  bus_err_a: assert property (PSLVERR |-> acc)
    else $error("stray error");
  bad_addr_a: assert property (acc && PADDR > `IFPD_OFS_STAT |-> PSLVERR)
    else $error("unmapped");
  ratio_sum_a: assert property (IF_RATIO == {1'b0, IF_MAIN, 4'h0} + 14'(IF_SWALLOW))
    else $error("ratio");
  cnt_load_a: assert property (wr0 && PWDATA[3:0] == `IFPD_CNT_CODE |-> ##2
    IF_MAIN == $past(PWDATA[12:4], 2) && IF_SWALLOW == $past(PWDATA[16:13], 2))
    else $error("count");
  ref_load_a: assert property (wr0 && PWDATA[4:0] == `IFPD_REF_CODE |-> ##2
    IF_REF_DIV == $past(PWDATA[13:5], 2))
    else $error("reference");
  tst_seen_a: assert property (wr0 && PWDATA[5:0] == `IFPD_TST_CODE |-> ##2 TEST_ACTIVE)
    else $error("test");
  dflt_out_a: assert property (dflt [*3] |-> !TEST_ACTIVE &&
    IF_MAIN == `IFPD_DEF_MAIN && IF_REF_DIV == `IFPD_DEF_REFD)
    else $error("default");
endmodule : ifpd_regs_chk
`default_nettype wire

// >>> test/ifpd_host.sv
// APB host model issuing one transfer per start pulse.
`timescale 1ns/1ps
`default_nettype none
module ifpd_host (
  input wire logic clk, // Clock
  input wire logic start, // Begin
  input wire logic [44:0] req, // Write, address, data
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  output logic psel, // Select
  output logic penable, // Enable
  output logic [44:0] preq, // Write, address, data
  output logic done, // Finished
  output logic [32:0] resp // Error and read data
);
  initial {psel, penable, preq, done, resp} = '0;
  always @(posedge clk)
  begin
    done <= psel && penable && pready;
    if (psel && penable && pready)
    begin
      {psel, penable} <= 2'b00;
      preq[31:0] <= ~preq[31:0];
      resp <= {pslverr, prdata};
    end
    else if (psel)
      penable <= 1'b1;
    else if (start)
      {psel, preq} <= {1'b1, req};
  end
endmodule : ifpd_host
`default_nettype wire

// >>> test/tb_ifpd_regs.sv
// Self-checking bench for the IF divider register bank.
`include "ifpd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ifpd_regs;
  logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TEST_ACTIVE, start, done;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] IF_SWALLOW, s;
  logic [8:0] IF_MAIN, IF_REF_DIV, m, r;
  logic [13:0] IF_RATIO;
  logic [23:0] TEST_WORD;
  logic [44:0] req;
  logic [32:0] resp;
  logic [15:0] lfsr;
  int num_errors, checks;
  ifpd_regs u_dut (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .IF_SWALLOW, .IF_MAIN, .IF_REF_DIV, .IF_RATIO, .TEST_ACTIVE, .TEST_WORD);
  ifpd_host u_host (.clk(CLK), .start, .req, .pready(PREADY), .prdata(PRDATA),
    .pslverr(PSLVERR), .psel(PSEL), .penable(PENABLE), .preq({PWRITE, PADDR, PWDATA}),
    .done, .resp);
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : step
  function automatic logic [31:0] cword(input logic [8:0] a, input logic [3:0] b);
    return {15'h0008, b, a, 4'h7};
  endfunction : cword
  task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic [44:0] q);
    @(posedge CLK);
    start <= 1'b1;
    req <= q;
    @(posedge CLK);
    start <= 1'b0;
    while (done !== 1'b1)
      @(negedge CLK);
    repeat (2) @(negedge CLK);
  endtask : xfer
  task automatic summarize;
    $display("Checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial
  begin
    #200_000;
    num_errors++;
    summarize();
  end
  initial
  begin
    {SRST, start, req, lfsr} = {1'b1, 46'h0, 16'h000C};
    num_errors = 0;
    checks = 0;
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    // Outputs lag the state by one edge, so defaults show after the first rising edge out of reset.
    repeat (2) @(negedge CLK);
    check("ratio", IF_RATIO, {`IFPD_DEF_MAIN, 4'h0} + `IFPD_DEF_SWAL);
    xfer({1'b0, `IFPD_OFS_CTRL, 32'h0});
    check("ctrl", resp, 33'h1);
    xfer({1'b1, `IFPD_OFS_CTRL, 32'h0});
    for (int i = 0; i < 12; i++)
    begin
      lfsr = step(lfsr);
      m = i == 0 ? 9'h001 : i == 1 ? 9'h1FF : lfsr[8:0] | 9'h010;
      s = i == 0 ? 4'h0 : i == 1 ? 4'hF : lfsr[12:9];
      r = i == 0 ? 9'h002 : lfsr[15:7] | 9'h002;
      xfer({1'b1, `IFPD_OFS_WORD, cword(m, s)});
      check("ratio", IF_RATIO, {m, 4'h0} + s);
      xfer({1'b0, `IFPD_OFS_COUNT, 32'h0});
      check("count", resp, cword(m, s));
      xfer({1'b1, `IFPD_OFS_WORD, 8'h00, 10'h0C2, r, 5'h0F});
      check("ref", IF_REF_DIV, r);
    end
    xfer({1'b0, `IFPD_OFS_REF, 32'h0});
    check("refword", resp, {9'h000, 10'h0C2, r, 5'h0F});
    xfer({1'b0, `IFPD_OFS_STAT, 32'h0});
    check("stat", resp, 33'h3);
    xfer({1'b1, `IFPD_OFS_WORD, 32'h0080_001F});
    xfer({1'b1, `IFPD_OFS_WORD, 32'h00FF_FFF3});
    check("test", {TEST_ACTIVE, TEST_WORD}, 25'h180_001F);
    check("keep", IF_RATIO, {m, 4'h0} + s);
    xfer({1'b0, `IFPD_OFS_STAT, 32'h0});
    check("stat", resp, 33'h7);
    xfer({1'b0, 12'h020, 32'h0});
    check("unmapped", resp[32], 1'b1);
    xfer({1'b1, `IFPD_OFS_CTRL, 32'h1});
    xfer({1'b1, `IFPD_OFS_WORD, cword(9'h1FF, 4'h3)});
    check("dflt", {TEST_ACTIVE, IF_MAIN, IF_REF_DIV, IF_SWALLOW},
      {`IFPD_DEF_MAIN, `IFPD_DEF_REFD, `IFPD_DEF_SWAL});
    xfer({1'b1, `IFPD_OFS_CTRL, 32'h0});
    check("stored", {IF_MAIN, IF_SWALLOW}, {9'h1FF, 4'h3});
    xfer({1'b1, `IFPD_OFS_WORD, cword(9'h000, 4'h0)});
    xfer({1'b0, `IFPD_OFS_STAT, 32'h0});
    check("bad", resp, 33'hF);
    summarize();
  end
endmodule : tb_ifpd_regs
bind ifpd_regs ifpd_regs_chk u_chk (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .PSLVERR, .IF_SWALLOW, .IF_MAIN, .IF_REF_DIV, .IF_RATIO, .TEST_ACTIVE);
`default_nettype wire
